// [edge_ff_map.svh]
// Constants for the edge flip-flop trio: initial-state select codes and the edge-detector reset value.
// Assumes inclusion by bare name from the package and the design file.
`ifndef EDGE_FF_MAP_SVH
`define EDGE_FF_MAP_SVH

// Initial-state select codes
`define INIT_SEL_ZERO    2'h0
`define INIT_SEL_ONE     2'h1
`define INIT_SEL_UNKNOWN 2'h2

// Reset values of the clock-edge detectors
`define EDGE_PREV_RESET  1'h0

`endif

// [edge_ff_pkg.sv]
// Types shared by the edge flip-flop trio.
// Assumes edge_ff_map.svh is on the include path.
`include "edge_ff_map.svh"

package edge_ff_pkg;

  // Initial-state select, codes 0 to 2
  typedef logic [1:0] init_state_t;

  // Stored state of one element: value plus unknown marker
  typedef struct packed {
    logic unknown;
    logic value;
  } bit_state_t;

  // State loaded at reset from an initial-state select
  function automatic bit_state_t init_state(input init_state_t sel);
    bit_state_t s;
    s.unknown = (sel == `INIT_SEL_UNKNOWN);
    s.value   = (sel == `INIT_SEL_ONE);
    return s;
  endfunction : init_state

  // Output seen now, with asynchronous set and reset overriding the store
  function automatic bit_state_t resolve(input bit_state_t stored, input logic force_one, input logic force_zero);
    bit_state_t s;
    s = stored;
    if (force_one && force_zero)
    begin
      s.unknown = 1'b1;
      s.value   = 1'b0;
    end
    else if (force_one)
    begin
      s.unknown = 1'b0;
      s.value   = 1'b1;
    end
    else if (force_zero)
    begin
      s.unknown = 1'b0;
      s.value   = 1'b0;
    end
    return s;
  endfunction : resolve

endpackage : edge_ff_pkg

// [edge_flip_flop_trio.sv]
// Three one-bit edge-triggered elements: J/K, toggle and set/reset.
// Assumes every input comes from logic on clk; each element clock is a
// same-domain strobe whose low-to-high change counts as its edge.
//
// Notes on behaviour
// [RQ1] J/K element stores one bit, changing only on its clock rising edge.
// [RQ2] J/K edge: 00 holds, 01 clears, 10 sets, 11 inverts.
// [RQ3] J/K: unknown on non-data inputs makes the output unknown.
// [RQ4] Toggle element inverts its bit on each clock rising edge when toggle high.
// [RQ5] Toggle: unknown on non-toggle inputs makes the output unknown at once.
// [RQ6] Set/reset edge: 10 stores one, 01 zero, 00 holds, 11 unknown.
// [RQ7] Set/reset: unknown on non-s/r inputs makes the output unknown at once.
// [RQ8] Each element has optional asynchronous set and reset; unconnected ones ignored.
// [RQ9] Asynchronous set forces one, asynchronous reset forces zero, no clock needed.
// [RQ10] Each element drives a true output and its inverse.
// [RQ11] Initial-state select 0 to 2, default 0, sets output before any event.

`timescale 1ns/1ps
`include "edge_ff_map.svh"

module edge_flip_flop_trio #(
  parameter edge_ff_pkg::init_state_t JK_INITIAL_STATE_SELECT = `INIT_SEL_ZERO,
  parameter edge_ff_pkg::init_state_t T_INITIAL_STATE_SELECT  = `INIT_SEL_ZERO,
  parameter edge_ff_pkg::init_state_t SR_INITIAL_STATE_SELECT = `INIT_SEL_ZERO,
  parameter bit                       JK_ASYNC_SET_USED       = 1'b1,
  parameter bit                       JK_ASYNC_RESET_USED     = 1'b1,
  parameter bit                       T_ASYNC_SET_USED        = 1'b1,
  parameter bit                       T_ASYNC_RESET_USED      = 1'b1,
  parameter bit                       SR_ASYNC_SET_USED       = 1'b1,
  parameter bit                       SR_ASYNC_RESET_USED     = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  // J/K element
  input  wire logic jk_clock,
  input  wire logic jk_j,
  input  wire logic jk_k,
  input  wire logic jk_async_set,
  input  wire logic jk_async_reset,
  output logic      jk_q,
  output logic      jk_q_n,
  output logic      jk_q_unknown,
  // Toggle element
  input  wire logic t_clock,
  input  wire logic t_toggle,
  input  wire logic t_async_set,
  input  wire logic t_async_reset,
  output logic      t_q,
  output logic      t_q_n,
  output logic      t_q_unknown,
  // Set/reset element
  input  wire logic sr_clock,
  input  wire logic sr_s,
  input  wire logic sr_r,
  input  wire logic sr_async_set,
  input  wire logic sr_async_reset,
  output logic      sr_q,
  output logic      sr_q_n,
  output logic      sr_q_unknown
);

  edge_ff_pkg::bit_state_t jk_stored;
  edge_ff_pkg::bit_state_t t_stored;
  edge_ff_pkg::bit_state_t sr_stored;
  edge_ff_pkg::bit_state_t jk_now;
  edge_ff_pkg::bit_state_t t_now;
  edge_ff_pkg::bit_state_t sr_now;
  logic                    jk_clock_prev;
  logic                    t_clock_prev;
  logic                    sr_clock_prev;
  logic                    jk_edge;
  logic                    t_edge;
  logic                    sr_edge;
  logic                    jk_force_one;
  logic                    jk_force_zero;
  logic                    t_force_one;
  logic                    t_force_zero;
  logic                    sr_force_one;
  logic                    sr_force_zero;

  // Unconnected asynchronous inputs are masked off
  assign jk_force_one  = JK_ASYNC_SET_USED   & jk_async_set;   // RQ8
  assign jk_force_zero = JK_ASYNC_RESET_USED & jk_async_reset; // RQ8
  assign t_force_one   = T_ASYNC_SET_USED    & t_async_set;    // RQ8
  assign t_force_zero  = T_ASYNC_RESET_USED  & t_async_reset;  // RQ8
  assign sr_force_one  = SR_ASYNC_SET_USED   & sr_async_set;   // RQ8
  assign sr_force_zero = SR_ASYNC_RESET_USED & sr_async_reset; // RQ8

  // Element clock edge detectors
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      jk_clock_prev <= `EDGE_PREV_RESET;
      t_clock_prev  <= `EDGE_PREV_RESET;
      sr_clock_prev <= `EDGE_PREV_RESET;
    end
    else
    begin
      jk_clock_prev <= jk_clock;
      t_clock_prev  <= t_clock;
      sr_clock_prev <= sr_clock;
    end
  end

  assign jk_edge = jk_clock & ~jk_clock_prev; // RQ1
  assign t_edge  = t_clock & ~t_clock_prev;   // RQ4
  assign sr_edge = sr_clock & ~sr_clock_prev;

  // Output seen now: asynchronous inputs act without waiting for an edge
  assign jk_now = edge_ff_pkg::resolve(jk_stored, jk_force_one, jk_force_zero); // RQ9
  assign t_now  = edge_ff_pkg::resolve(t_stored, t_force_one, t_force_zero);    // RQ9
  assign sr_now = edge_ff_pkg::resolve(sr_stored, sr_force_one, sr_force_zero); // RQ9

  // J/K store; an asynchronous force is captured so it holds after release
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      jk_stored <= edge_ff_pkg::init_state(JK_INITIAL_STATE_SELECT); // RQ11
    end
    else if (jk_force_one || jk_force_zero)
    begin
      jk_stored <= jk_now; // RQ9
    end
    else if (jk_edge) // RQ1
    begin
      unique case ({jk_j, jk_k})
        2'b00:
        begin
          jk_stored <= jk_stored; // RQ2
        end
        2'b01:
        begin
          jk_stored <= '{unknown: 1'b0, value: 1'b0}; // RQ2
        end
        2'b10:
        begin
          jk_stored <= '{unknown: 1'b0, value: 1'b1}; // RQ2
        end
        2'b11:
        begin
          // An unknown bit stays unknown, its value kept low
          if (!jk_stored.unknown)
          begin
            jk_stored <= '{unknown: 1'b0, value: ~jk_stored.value}; // RQ2 RQ3
          end
        end
      endcase
    end
  end

  // Toggle store
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      t_stored <= edge_ff_pkg::init_state(T_INITIAL_STATE_SELECT); // RQ11
    end
    else if (t_force_one || t_force_zero)
    begin
      t_stored <= t_now; // RQ9
    end
    else if (t_edge && t_toggle && !t_stored.unknown)
    begin
      // An unknown bit is left as it is, value kept low
      t_stored <= '{unknown: 1'b0, value: ~t_stored.value}; // RQ4 RQ5
    end
  end

  // Set/reset store
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sr_stored <= edge_ff_pkg::init_state(SR_INITIAL_STATE_SELECT); // RQ11
    end
    else if (sr_force_one || sr_force_zero)
    begin
      sr_stored <= sr_now; // RQ9
    end
    else if (sr_edge)
    begin
      unique case ({sr_s, sr_r})
        2'b00:
        begin
          sr_stored <= sr_stored; // RQ6
        end
        2'b01:
        begin
          sr_stored <= '{unknown: 1'b0, value: 1'b0}; // RQ6
        end
        2'b10:
        begin
          sr_stored <= '{unknown: 1'b0, value: 1'b1}; // RQ6
        end
        2'b11:
        begin
          sr_stored <= '{unknown: 1'b1, value: 1'b0}; // RQ6
        end
      endcase
    end
  end

  // True and inverted outputs; both read low while unknown is flagged
  assign jk_q         = jk_now.value;                          // RQ10
  assign jk_q_n       = ~jk_now.value & ~jk_now.unknown;       // RQ10
  assign jk_q_unknown = jk_now.unknown;                        // RQ3
  assign t_q          = t_now.value;                           // RQ10
  assign t_q_n        = ~t_now.value & ~t_now.unknown;         // RQ10
  assign t_q_unknown  = t_now.unknown;                         // RQ5
  assign sr_q         = sr_now.value;                          // RQ10
  assign sr_q_n       = ~sr_now.value & ~sr_now.unknown;       // RQ10
  assign sr_q_unknown = sr_now.unknown;                        // RQ7

endmodule : edge_flip_flop_trio

// [edge_flip_flop_trio_checker.sv]
// Assertions on the ports of the edge flip-flop trio.
// Assumes it is bound into edge_flip_flop_trio; rst is asynchronous, active high.
`timescale 1ns/1ps
module edge_flip_flop_trio_checker #(
  parameter bit JK_ASYNC_SET_USED   = 1'b1,
  parameter bit JK_ASYNC_RESET_USED = 1'b1,
  parameter bit T_ASYNC_SET_USED    = 1'b1,
  parameter bit T_ASYNC_RESET_USED  = 1'b1,
  parameter bit SR_ASYNC_SET_USED   = 1'b1,
  parameter bit SR_ASYNC_RESET_USED = 1'b1
) (
  input wire logic clk, rst, jk_clock, jk_j, jk_k, jk_async_set, jk_async_reset,
  input wire logic jk_q, jk_q_n, jk_q_unknown, t_clock, t_toggle, t_async_set,
  input wire logic t_async_reset, t_q, t_q_n, t_q_unknown, sr_clock, sr_s, sr_r,
  input wire logic sr_async_set, sr_async_reset, sr_q, sr_q_n, sr_q_unknown
);
  logic live, pj, pt, ps;
  // Asynchronous inputs as the element sees them, unconnected ones masked
  wire js = JK_ASYNC_SET_USED & jk_async_set;
  wire jr = JK_ASYNC_RESET_USED & jk_async_reset;
  wire aj = js | jr;
  wire at = (T_ASYNC_SET_USED & t_async_set) | (T_ASYNC_RESET_USED & t_async_reset);
  wire asr = (SR_ASYNC_SET_USED & sr_async_set) | (SR_ASYNC_RESET_USED & sr_async_reset);
  wire ej = live & jk_clock & ~pj & ~aj;
  wire et = live & t_clock & ~pt & ~at;
  wire es = live & sr_clock & ~ps & ~asr;
  // Element clocks at the last clk edge; live skips the release edge
  always_ff @(posedge clk or posedge rst)
    if (rst) {live, pj, pt, ps} <= 4'h0;
    else {live, pj, pt, ps} <= {1'b1, jk_clock, t_clock, sr_clock};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_jk_load: assert property (ej && jk_j != jk_k |=> aj || (jk_q == $past(jk_j) && !jk_q_unknown))
    else $error("jk load");
  a_jk_invert: assert property (ej && jk_j && jk_k && !jk_q_unknown |=> aj || jk_q != $past(jk_q))
    else $error("jk invert");
  a_jk_hold: assert property (live && !ej && !aj |=> aj || $stable(jk_q))
    else $error("jk hold");
  a_t_toggle: assert property (et && t_toggle && !t_q_unknown |=> at || t_q != $past(t_q))
    else $error("t toggle");
  a_sr_load: assert property (es && sr_s != sr_r |=> asr || (sr_q == $past(sr_s) && !sr_q_unknown))
    else $error("sr load");
  a_sr_both: assert property (es && sr_s && sr_r |=> asr || sr_q_unknown)
    else $error("sr both");
  a_async_set: assert property (js && !jr |-> jk_q && !jk_q_n)
    else $error("async set");
  a_q_inverse: assert property ((jk_q ^ jk_q_n) != jk_q_unknown && (t_q ^ t_q_n) != t_q_unknown
    && (sr_q ^ sr_q_n) != sr_q_unknown)
    else $error("q inverse");
endmodule : edge_flip_flop_trio_checker

bind edge_flip_flop_trio edge_flip_flop_trio_checker #(
  .JK_ASYNC_SET_USED(JK_ASYNC_SET_USED), .JK_ASYNC_RESET_USED(JK_ASYNC_RESET_USED),
  .T_ASYNC_SET_USED(T_ASYNC_SET_USED), .T_ASYNC_RESET_USED(T_ASYNC_RESET_USED),
  .SR_ASYNC_SET_USED(SR_ASYNC_SET_USED), .SR_ASYNC_RESET_USED(SR_ASYNC_RESET_USED)
) chk (.*);

// [edge_ff_stim.sv]
// Surrounding logic: random element clocks, data and async inputs.
// Assumes clk from the bench; changes every output at each rising edge.
`timescale 1ns/1ps
module edge_ff_stim (
  input  wire logic clk,
  output logic      jk_clock, jk_j, jk_k, jk_async_set, jk_async_reset,
  output logic      t_clock, t_toggle, t_async_set, t_async_reset,
  output logic      sr_clock, sr_s, sr_r, sr_async_set, sr_async_reset
);
  integer      seed = 54400;
  logic [31:0] r    = 32'h0;
  always @(posedge clk)
    r <= $random(seed);
  assign {jk_clock, t_clock, sr_clock, jk_j, jk_k, t_toggle, sr_s, sr_r} = r[7:0];
  // Async inputs held rare, one edge in eight
  assign {jk_async_set, jk_async_reset} = {&r[10:8], &r[13:11]};
  assign {t_async_set, t_async_reset} = {&r[16:14], &r[19:17]};
  assign {sr_async_set, sr_async_reset} = {&r[22:20], &r[25:23]};
endmodule : edge_ff_stim

// [edge_flip_flop_trio_tb_top.sv]
// Self-checking bench: reference model queues expected outputs each cycle.
// Assumes edge_ff_stim drives every element input.
`timescale 1ns/1ps
`include "edge_ff_map.svh"
module edge_flip_flop_trio_tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  wire        jk_clock, jk_j, jk_k, jk_async_set, jk_async_reset, jk_q, jk_q_n, jk_q_unknown;
  wire        t_clock, t_toggle, t_async_set, t_async_reset, t_q, t_q_n, t_q_unknown;
  wire        sr_clock, sr_s, sr_r, sr_async_set, sr_async_reset, sr_q, sr_q_n, sr_q_unknown;
  wire        mjq, mjqn, mju, mtq, mtqn, mtu, msq, msqn, msu;
  logic [1:0] sj, st, ss, mj, mt, ms;
  logic       pj, pt, ps;
  logic [17:0] e;
  logic [17:0] exp_q[$];
  int         n_mismatch = 0;
  int         cmp_count  = 0;
  edge_flip_flop_trio #(.JK_INITIAL_STATE_SELECT(`INIT_SEL_ONE),
    .T_INITIAL_STATE_SELECT(`INIT_SEL_UNKNOWN)) dut (.*);
  // Same inputs, every asynchronous input left unconnected
  edge_flip_flop_trio #(.JK_INITIAL_STATE_SELECT(`INIT_SEL_ZERO), .T_INITIAL_STATE_SELECT(`INIT_SEL_ONE),
    .SR_INITIAL_STATE_SELECT(`INIT_SEL_UNKNOWN), .JK_ASYNC_SET_USED(1'b0), .JK_ASYNC_RESET_USED(1'b0),
    .T_ASYNC_SET_USED(1'b0), .T_ASYNC_RESET_USED(1'b0), .SR_ASYNC_SET_USED(1'b0),
    .SR_ASYNC_RESET_USED(1'b0)) masked (.*, .jk_q(mjq), .jk_q_n(mjqn), .jk_q_unknown(mju), .t_q(mtq),
    .t_q_n(mtqn), .t_q_unknown(mtu), .sr_q(msq), .sr_q_n(msqn), .sr_q_unknown(msu));
  edge_ff_stim stim (.*);
  // State as {unknown, value}; async pair resolves over it
  function automatic logic [1:0] frc(logic [1:0] s, logic a, logic b);
    return (a & b) ? 2'h2 : a ? 2'h1 : b ? 2'h0 : s;
  endfunction : frc
  function automatic logic [2:0] outs(logic [1:0] s);
    return {s[1], ~s[1] & s[0], ~s[1] & ~s[0]};
  endfunction : outs
  function automatic logic [1:0] inv(logic [1:0] s);
    return s[1] ? s : {1'b0, ~s[0]};
  endfunction : inv
  function automatic logic [1:0] jkn(logic [1:0] s, logic j, logic k);
    return j ? (k ? inv(s) : 2'h1) : (k ? 2'h0 : s);
  endfunction : jkn
  function automatic logic [1:0] srn(logic [1:0] s, logic a, logic b);
    return a ? (b ? 2'h2 : 2'h1) : (b ? 2'h0 : s);
  endfunction : srn
  task automatic check(input logic [2:0] seen, input logic [2:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %b want %b", $time, seen, want);
    end
  endtask : check
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  always @(posedge clk)
  begin
    if (!rst)
    begin
      if (jk_async_set | jk_async_reset) sj = frc(sj, jk_async_set, jk_async_reset);
      else if (jk_clock & ~pj) sj = jkn(sj, jk_j, jk_k);
      if (jk_clock & ~pj) mj = jkn(mj, jk_j, jk_k);
      if (t_async_set | t_async_reset) st = frc(st, t_async_set, t_async_reset);
      else if (t_clock & ~pt & t_toggle) st = inv(st);
      if (t_clock & ~pt & t_toggle) mt = inv(mt);
      if (sr_async_set | sr_async_reset) ss = frc(ss, sr_async_set, sr_async_reset);
      else if (sr_clock & ~ps) ss = srn(ss, sr_s, sr_r);
      if (sr_clock & ~ps) ms = srn(ms, sr_s, sr_r);
      {pj, pt, ps} = {jk_clock, t_clock, sr_clock};
    end
    #1;
    if (rst)
    begin
      {sj, st, ss} = {`INIT_SEL_ONE, `INIT_SEL_UNKNOWN, `INIT_SEL_ZERO};
      {mj, mt, ms} = {`INIT_SEL_ZERO, `INIT_SEL_ONE, `INIT_SEL_UNKNOWN};
      {pj, pt, ps} = 3'h0;
    end
    exp_q.push_back({outs(frc(sj, jk_async_set, jk_async_reset)), outs(frc(st, t_async_set, t_async_reset)),
      outs(frc(ss, sr_async_set, sr_async_reset)), outs(mj), outs(mt), outs(ms)});
  end
  always @(negedge clk)
    if (exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check({jk_q_unknown, jk_q, jk_q_n}, e[17:15]);
      check({t_q_unknown, t_q, t_q_n}, e[14:12]);
      check({sr_q_unknown, sr_q, sr_q_n}, e[11:9]);
      check({mju, mjq, mjqn}, e[8:6]);
      check({mtu, mtq, mtqn}, e[5:3]);
      check({msu, msq, msqn}, e[2:0]);
    end
  initial
    forever #2.5 clk = ~clk;
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2000) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2000) @(posedge clk);
    test_done();
  end
endmodule : edge_flip_flop_trio_tb_top
